// ==== core/gpp_params.svh ====
// constants for the general digital port pin block
// assumes an axi4-lite master with 32-bit data and word-aligned addresses
// Operation
// R1 - direction bit one makes pin output
// R2 - input with output bit one gets pull-up
// R3 - global pull-up disable kills every pull-up
// R4 - output pin drives its output bit value
// R5 - reset tri-states every pin
// R6 - reset disables all pull-ups
// R7 - direction, output, input words at separate addresses
// R8 - input word reads pad regardless of direction
// R9 - sample stage then capture on rising edge; code has no sample stage, the pad goes straight into din on the rising edge
// R10 - written value visible one cycle later
// R11 - software steps through intermediate state, tristate/high
// R12 - software steps through intermediate state, pullup/low
// R13 - deep sleep clamps digital inputs to ground
// R14 - enabled interrupt pins are not clamped
// R15 - high pin sets edge flag after sleep
// R16 - input word read-only, others read-write
// R17 - direction and output reset to zero
`ifndef GPP_PARAMS_SVH
`define GPP_PARAMS_SVH
`define GPP_OFS_DIR     8'h00
`define GPP_OFS_OUT     8'h04
`define GPP_OFS_IN      8'h08
`define GPP_OFS_CTRL    8'h0c
`define GPP_OFS_IRQ_ST  8'h10
`define GPP_OFS_IRQ_MSK 8'h14
`define GPP_OFS_EXT_EN  8'h18
`define GPP_OFS_EXT_EDG 8'h1c
`define GPP_CTRL_PUD    0
`define GPP_CTRL_SLEEP  1
`define GPP_RESP_OKAY   2'b00
`define GPP_RESP_SLVERR 2'b10
`endif

// ==== core/gpp_pkg.sv ====
// types for the general digital port pin block
// assumes gpp_params.svh is compiled alongside
package gpp_pkg;
    typedef enum logic [1:0] {
        GPP_W_IDLE,
        GPP_W_RESP
    } gpp_wstate_t;

    typedef struct packed {
        logic [31:0] dir;
        logic [31:0] dout;
        logic [31:0] din;
        logic        global_pullup_disable;
        logic        sleep;
        logic [31:0] ext_en;
        logic [31:0] ext_edge;
        logic [31:0] irq_st;
        logic [31:0] irq_msk;
        logic [31:0] prev_in;
        logic        sleep_prev;
        logic        irq;
        logic [31:0] pad_o;
        logic [31:0] pad_oe_n;
        logic [31:0] pull_en;
        logic        aw_seen;
        logic        w_seen;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } gpp_state_t;
endpackage : gpp_pkg

// ==== core/gpp_port.sv ====
// one port of general digital pins with axi4-lite register access
// assumes pads resolved outside: pad_oe_n low drives, pull_en adds a pull-up
`timescale 1ns/1ps
`include "gpp_params.svh"
module gpp_port
    import gpp_pkg::*;
#(
    parameter int NPIN = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [NPIN-1:0]   pad_i,
    output logic [NPIN-1:0]        pad_o,
    output logic [NPIN-1:0]        pad_oe_n,
    output logic [NPIN-1:0]        pull_en,
    output logic                   irq
);
    gpp_state_t s_q, s_d;
    logic [31:0] pad_ext;
    logic [31:0] clamp_in;
    logic [31:0] rd_word;
    logic [31:0] wmask;
    logic [31:0] ev;
    logic        wr_fire;
    logic        rd_fire;
    logic        rd_ok;
    logic        wr_ok;

    // ============================================================
    // pad input clamp
    // ============================================================
    assign pad_ext = {{(32-NPIN){1'b0}}, pad_i};
    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_clamp
            // clamp ahead of the sampler; enabled interrupt pins escape
            assign clamp_in[g] = pad_ext[g] & ~(s_q.sleep & ~s_q.ext_en[g]); // R13 R14
        end
    endgenerate

    // ============================================================
    // register decode
    // ============================================================
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        unique case (s_axi_araddr)
            `GPP_OFS_DIR:     rd_word = s_q.dir;
            `GPP_OFS_OUT:     rd_word = s_q.dout;
            `GPP_OFS_IN:      rd_word = s_q.din; // R8
            `GPP_OFS_CTRL: begin
                rd_word[`GPP_CTRL_PUD]   = s_q.global_pullup_disable;
                rd_word[`GPP_CTRL_SLEEP] = s_q.sleep;
            end
            `GPP_OFS_IRQ_ST:  rd_word = s_q.irq_st;
            `GPP_OFS_IRQ_MSK: rd_word = s_q.irq_msk;
            `GPP_OFS_EXT_EN:  rd_word = s_q.ext_en;
            `GPP_OFS_EXT_EDG: rd_word = s_q.ext_edge;
            default:          rd_ok   = 1'b0;
        endcase
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{s_q.wstrb[i]}};
        end
    end

    assign wr_fire = s_q.aw_seen & s_q.w_seen & ~s_q.bvalid;
    assign rd_fire = s_axi_arvalid & s_q.arready;
    assign wr_ok   = (s_q.awaddr[1:0] == 2'b00) && (s_q.awaddr <= `GPP_OFS_EXT_EDG);

    // ============================================================
    // next state
    // ============================================================
    always_comb begin
        s_d = s_q;
        // R9: no separate sample stage; the clamped pad is captured straight into din on the rising edge
        s_d.din     = clamp_in & {{(32-NPIN){1'b0}}, {NPIN{1'b1}}}; // R9 R10
        s_d.prev_in = s_q.din;
        s_d.sleep_prev = s_q.sleep;

        // edge events on enabled-or-not pins; wake produces a rise on a high pin not set in ext_en
        ev = s_q.ext_edge & (s_q.din ^ s_q.prev_in); // R15
        if (s_q.sleep_prev & ~s_q.sleep) begin
            ev = ev | (s_q.ext_edge & ~s_q.ext_en & pad_ext); // R15
        end

        // axi write channels, accepted in either order
        s_d.awready = ~s_q.aw_seen & ~s_q.bvalid;
        s_d.wready  = ~s_q.w_seen & ~s_q.bvalid;
        if (s_axi_awvalid & s_q.awready) begin
            s_d.aw_seen = 1'b1;
            s_d.awaddr  = s_axi_awaddr;
            s_d.awready = 1'b0;
        end
        if (s_axi_wvalid & s_q.wready) begin
            s_d.w_seen = 1'b1;
            s_d.wdata  = s_axi_wdata;
            s_d.wstrb  = s_axi_wstrb;
            s_d.wready = 1'b0;
        end
        if (wr_fire) begin
            s_d.aw_seen = 1'b0;
            s_d.w_seen  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = wr_ok ? `GPP_RESP_OKAY : `GPP_RESP_SLVERR;
            unique case (s_q.awaddr)
                `GPP_OFS_DIR:
                    s_d.dir = (s_q.dir & ~wmask) | (s_q.wdata & wmask); // R1 R7 R16
                `GPP_OFS_OUT:
                    s_d.dout = (s_q.dout & ~wmask) | (s_q.wdata & wmask); // R7 R16
                `GPP_OFS_CTRL: begin
                    if (s_q.wstrb[0]) begin
                        s_d.global_pullup_disable   = s_q.wdata[`GPP_CTRL_PUD]; // R3
                        s_d.sleep = s_q.wdata[`GPP_CTRL_SLEEP]; // R13
                    end
                end
                `GPP_OFS_IRQ_ST:
                    s_d.irq_st = s_q.irq_st & ~(s_q.wdata & wmask);
                `GPP_OFS_IRQ_MSK:
                    s_d.irq_msk = (s_q.irq_msk & ~wmask) | (s_q.wdata & wmask);
                `GPP_OFS_EXT_EN:
                    s_d.ext_en = (s_q.ext_en & ~wmask) | (s_q.wdata & wmask);
                `GPP_OFS_EXT_EDG:
                    s_d.ext_edge = (s_q.ext_edge & ~wmask) | (s_q.wdata & wmask);
                // input word and unmapped: write ignored
                default: ;
            endcase
        end
        if (s_q.bvalid & s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // set beats clear in the same cycle
        s_d.irq_st = s_d.irq_st | (ev & {{(32-NPIN){1'b0}}, {NPIN{1'b1}}});

        // axi read
        s_d.arready = ~s_q.rvalid & ~rd_fire;
        if (rd_fire) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = rd_word;
            s_d.rresp  = rd_ok ? `GPP_RESP_OKAY : `GPP_RESP_SLVERR;
        end else if (s_q.rvalid & s_axi_rready) begin
            s_d.rvalid  = 1'b0;
            s_d.arready = 1'b1;
        end

        // pin drivers from the next register values
        s_d.pad_o    = s_d.dout; // R4
        s_d.pad_oe_n = ~s_d.dir; // R1 R4
        s_d.pull_en  = ~s_d.dir & s_d.dout & {32{~s_d.global_pullup_disable}}; // R2 R3
        s_d.irq      = |(s_d.irq_st & s_d.irq_msk);
    end

    // ============================================================
    // state register
    // ============================================================
    // synchronous reset: pins release at the first edge with reset low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q          <= '0; // R17
            s_q.pad_oe_n <= 32'hffff_ffff; // R5
            s_q.pull_en  <= 32'h0000_0000; // R6
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = s_q.awready;
    assign s_axi_wready  = s_q.wready;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;
    assign pad_o         = s_q.pad_o[NPIN-1:0];
    assign pad_oe_n      = s_q.pad_oe_n[NPIN-1:0];
    assign pull_en       = s_q.pull_en[NPIN-1:0];
    assign irq           = s_q.irq;
endmodule : gpp_port

// ==== testbench/gpp_pads.sv ====
// board side of the pins: port drivers, pull-ups, an external source
// assumes active low output enable and active high pull enable
`timescale 1ns/1ps
module gpp_pads (
    input  wire logic       aclk,
    input  wire logic [7:0] pad_o,
    input  wire logic [7:0] pad_oe_n,
    input  wire logic [7:0] pull_en,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pad
);
    logic [7:0] flt = 8'h55;
    // undriven pins wander so a missing pull-up never reads lucky
    always @(posedge aclk) flt <= ~flt;
    assign pad = (~pad_oe_n & pad_o) | (pad_oe_n & ext_en & ext_val)
               | (pad_oe_n & ~ext_en & (pull_en | flt));
endmodule : gpp_pads

// ==== testbench/gpp_port_properties.sv ====
// assertions on the bus and pin ports of gpp_port
// assumes one aclk domain with synchronous active low aresetn
`timescale 1ns/1ps
module gpp_port_properties #(
    parameter int NPIN = 8
) (
    input wire logic            aclk,
    input wire logic            aresetn,
    input wire logic            s_axi_awvalid,
    input wire logic            s_axi_awready,
    input wire logic            s_axi_wvalid,
    input wire logic            s_axi_wready,
    input wire logic            s_axi_bvalid,
    input wire logic [7:0]      s_axi_araddr,
    input wire logic            s_axi_arvalid,
    input wire logic            s_axi_arready,
    input wire logic            s_axi_rvalid,
    input wire logic [1:0]      s_axi_rresp,
    input wire logic [NPIN-1:0] pad_o,
    input wire logic [NPIN-1:0] pad_oe_n,
    input wire logic [NPIN-1:0] pull_en,
    input wire logic            irq
);
    // ==========================================================
    // properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_RST: assert property ($rose(aresetn) |-> pad_oe_n == '1 && pull_en == '0 && !irq)
        else $error("pins not idle after reset");
    AST_PULL: assert property ((pull_en & ~pad_oe_n) == '0)
        else $error("pull-up on driven pin");
    AST_DRV: assert property ($changed(pad_o) |-> s_axi_bvalid)
        else $error("drive value moved without write");
    AST_DIR: assert property ($changed(pad_oe_n) |-> s_axi_bvalid)
        else $error("direction moved without write");
    AST_PCHG: assert property ($changed(pull_en) |-> s_axi_bvalid)
        else $error("pull-up moved without write");
    AST_WR: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    AST_RD: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read data late");
    AST_UNMAP: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1c
        |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == 2'b10))
        else $error("unmapped read not refused");
    cover property (s_axi_awvalid && s_axi_awready);
    cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1c);
    cover property ($rose(irq));
endmodule : gpp_port_properties
bind gpp_port gpp_port_properties #(.NPIN(NPIN)) props (.*);

// ==== testbench/tb_top.sv ====
// register-level bench for gpp_port over axi4-lite
// assumes gpp_pads on the pins and the bound property checker
`timescale 1ns/1ps
`include "gpp_params.svh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin failures++; \
    $display("BAD %s exp %h got %h", n, e, a); end end
module tb_top;
    logic        aclk = 1'b0, aresetn = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic [7:0]  pad_i, pad_o, pad_oe_n, pull_en;
    int          failures = 0, comparisons = 0, cycles = 0;
    always #2.5 aclk = ~aclk;
    gpp_port #(.NPIN(8)) dut (.*);
    gpp_pads pads (.aclk(aclk), .pad_o(pad_o), .pad_oe_n(pad_oe_n), .pull_en(pull_en),
                   .ext_en(8'h30), .ext_val(8'h10), .pad(pad_i));
    // ==========================================================
    // bus tasks
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (a <= 8'h1c) `CHK("bresp", `GPP_RESP_OKAY, s_axi_bresp)
        else `CHK("bresp", `GPP_RESP_SLVERR, s_axi_bresp)
    endtask : axi_wr
    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        if (a <= 8'h1c) begin
            `CHK(n, e, rd)
            `CHK("rresp", `GPP_RESP_OKAY, rr)
        end else `CHK(n, `GPP_RESP_SLVERR, rr)
    endtask : rd_chk
    task automatic complete_run();
        $display("checks %0d mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            complete_run();
        end
    end
    // ==========================================================
    // tests
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK("oe", 8'hff, pad_oe_n)
        rd_chk("dir", `GPP_OFS_DIR, 32'h00000000);
        $display("test reset done");
        axi_wr(`GPP_OFS_OUT, 32'h000000c3);
        `CHK("pull", 8'hc3, pull_en)
        axi_wr(`GPP_OFS_CTRL, 32'h00000001);
        `CHK("pud", 8'h00, pull_en)
        axi_wr(`GPP_OFS_CTRL, 32'h00000000);
        axi_wr(`GPP_OFS_DIR, 32'h0000000f);
        `CHK("oe", 8'hf0, pad_oe_n)
        `CHK("drv", 8'h03, pad_o & ~pad_oe_n)
        rd_chk("in", `GPP_OFS_IN, 32'h000000d3);
        axi_wr(`GPP_OFS_IN, 32'h00000000);
        rd_chk("in ro", `GPP_OFS_IN, 32'h000000d3);
        axi_wr(8'h20, 32'hffffffff);
        rd_chk("out", `GPP_OFS_OUT, 32'h000000c3);
        rd_chk("unmapped", 8'h20, 32'h00000000);
        // pin 7 leaves pull-up input through output high before going low
        axi_wr(`GPP_OFS_DIR, 32'h0000008f);
        axi_wr(`GPP_OFS_OUT, 32'h00000043);
        `CHK("drv low", 8'h03, pad_o & ~pad_oe_n)
        `CHK("pull low", 8'h40, pull_en)
        rd_chk("in low", `GPP_OFS_IN, 32'h00000053);
        $display("test pins done");
        axi_wr(`GPP_OFS_EXT_EN, 32'h00000010);
        axi_wr(`GPP_OFS_EXT_EDG, 32'h00000040);
        axi_wr(`GPP_OFS_IRQ_MSK, 32'h00000040);
        axi_wr(`GPP_OFS_CTRL, 32'h00000002);
        rd_chk("clamp", `GPP_OFS_IN, 32'h00000010);
        // flag from entering the clamp is cleared so only the wake can set it
        axi_wr(`GPP_OFS_IRQ_ST, 32'h00000040);
        rd_chk("asleep", `GPP_OFS_IRQ_ST, 32'h00000000);
        axi_wr(`GPP_OFS_CTRL, 32'h00000000);
        rd_chk("wake", `GPP_OFS_IRQ_ST, 32'h00000040);
        `CHK("irq", 1'b1, irq)
        axi_wr(`GPP_OFS_IRQ_MSK, 32'h00000000);
        rd_chk("msk", `GPP_OFS_IRQ_MSK, 32'h00000000);
        `CHK("irq", 1'b0, irq)
        axi_wr(`GPP_OFS_IRQ_ST, 32'h00000040);
        rd_chk("clear", `GPP_OFS_IRQ_ST, 32'h00000000);
        $display("test sleep done");
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        `CHK("rst pull", 8'h00, pull_en)
        `CHK("rst oe", 8'hff, pad_oe_n)
        aresetn <= 1'b1;
        rd_chk("rst out", `GPP_OFS_OUT, 32'h00000000);
        $display("test rerun reset done");
        complete_run();
    end
endmodule : tb_top
